// [pkg/fault_sup_pkg.sv]
// Purpose: shared constants and carriers for the laser fault supervisor
// Assumes: 50 MHz system clock, register port with one-cycle read latency
// Notes:   offsets are word indices on the plain register port
package fault_sup_pkg;

    localparam int unsigned CLK_HZ             = 50_000_000;
    // glitch filter time in microseconds
    localparam int unsigned GLITCH_US          = 10_000;
    localparam int unsigned GLITCH_CYC         = (CLK_HZ / 1_000_000) * GLITCH_US;
    // blanking step in microseconds, one count of saturation_blank_interval
    localparam int unsigned BLANK_STEP_US      = 500;
    localparam int unsigned BLANK_STEP_CYC     = (CLK_HZ / 1_000_000) * BLANK_STEP_US;

    localparam logic [7:0] TEMP_FULL_SCALE     = 8'h7F;

    // register offsets
    localparam logic [3:0] OFS_FAULT_MASK      = 4'h0;
    localparam logic [3:0] OFS_BLANK           = 4'h1;
    localparam logic [3:0] OFS_LOS_ASSERT      = 4'h2;
    localparam logic [3:0] OFS_LOS_DEASSERT    = 4'h3;
    localparam logic [3:0] OFS_CFG_ONE         = 4'h4;
    localparam logic [3:0] OFS_CFG_THREE       = 4'h5;
    localparam logic [3:0] OFS_CONTROL         = 4'h6;
    localparam logic [3:0] OFS_BIAS_FLT_SET    = 4'h7;
    localparam logic [3:0] OFS_TEMP            = 4'h8;
    localparam logic [3:0] OFS_FAULT_STAT      = 4'h9;

    // reset values
    localparam logic [4:0] FAULT_MASK_RST      = 5'h00;
    localparam logic [7:0] BLANK_RST           = 8'h01;
    localparam logic [7:0] LOS_ASSERT_RST      = 8'h20;
    localparam logic [7:0] LOS_DEASSERT_RST    = 8'h30;
    localparam logic [7:0] BIAS_FLT_SET_RST    = 8'hC0;

    // fault source indices
    localparam int unsigned SRC_SUPPLY         = 0;
    localparam int unsigned SRC_DIODE          = 1;
    localparam int unsigned SRC_BIAS           = 2;
    localparam int unsigned SRC_POWER          = 3;
    localparam int unsigned SRC_SAT            = 4;
    localparam int unsigned NUM_SRC            = 5;

    // oem_config_one bits
    typedef struct packed {
        logic       output_enable;
        logic       safety_output_polarity;
        logic       zone_external;
        logic       bias_ref_high;
        logic       mod_ref_high;
        logic       diode_fault_flag;
        logic [1:0] spare;
    } cfg_one_s;

    // oem_config_three bits
    typedef struct packed {
        logic       safety_enable;
        logic       external_fault_mode;
        logic       ext_fault_input_polarity;
        logic       los_comparator_disable;
        logic [3:0] spare;
    } cfg_three_s;

    localparam logic [7:0] CFG_ONE_RST         = 8'h00;
    localparam logic [7:0] CFG_THREE_RST       = 8'h00;

    // raw analog-side comparator and converter results
    typedef struct packed {
        logic       supply_low;
        logic       bias_over;
        logic       power_over;
        logic       apc_saturated;
        logic       diode_open_short;
        logic       conv_done;
        logic [7:0] temp_internal;
        logic [7:0] temp_external;
        logic [7:0] rx_power_sense;
        logic [7:0] bias_sense;
    } sense_s;

    typedef struct packed {
        logic       drive;
        logic       enable;
    } pin_drive_s;

endpackage

// [hw/laser_fault_supervisor.sv]
// Purpose: fault supervision and laser shutdown for an optical module controller
// Assumes: all inputs synchronous to clk_in; digitised comparator levels
// Notes:   analog comparators, dacs and lookup arithmetic stay outside
//
// Behaviour
// - five fault sources shut laser, assert fault
// - each source masked by a stored bit
// - saturation ignored for programmable blanking after turn-on
// - supply, bias, power and saturation pulses under ten milliseconds are rejected
// - loss-of-signal asserts low, deasserts above second level
// - comparator disable releases rx los pin
// - status shows actual rx los pin level
// - bias threshold offset by temperature table entry
// - on fault drive outputs to configured shutdown levels
// - safety output at shutdown level whenever laser is off
// - safety output push-pull with selectable polarity
// - external fault mode turns shared pin input
// - external fault ored into fault output and status
// - zone bit selects internal or external junction
// - diode fault forces temperature to full scale
// - diode fault sets flag, fault, temp alarms
// - toggling tx disable clears latched faults
// - no diode fault before first conversion completes
// - diode faults not reported while tx disabled
// - output enable clear floats all laser outputs
// - safety shutdown level follows polarity bit
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module laser_fault_supervisor
(
    // clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        nrst_in,
    // register port
    input  wire logic [3:0]                  addr_in,
    input  wire logic [7:0]                  wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic      [7:0]                  rdata_out,
    // analog side
    input  wire fault_sup_pkg::sense_s       sense_in,
    input  wire logic signed [7:0]           bias_lut_offset_in,
    output logic      [7:0]                  bias_fault_ref_out,
    output logic                             temp_zone_external_out,
    // host pins
    input  wire logic                        tx_disable_in,
    output logic                             tx_fault_out,
    input  wire logic                        rx_los_in,
    output logic                             rx_los_out,
    output logic                             rx_los_oe_out,
    // shared safety / external fault pin
    input  wire logic                        safety_pin_in,
    output logic                             safety_switch_drive_out,
    output logic                             safety_switch_drive_oe_out,
    // laser drive shutdown
    output fault_sup_pkg::pin_drive_s        modulation_dac_out,
    output fault_sup_pkg::pin_drive_s        bias_dac_out,
    output logic                             laser_on_out,
    // temperature report
    output logic      [7:0]                  temperature_out,
    output logic                             temp_high_alarm_out,
    output logic                             temp_high_warn_out
);

    localparam logic [19:0] GLITCH_LAST = 20'(fault_sup_pkg::GLITCH_CYC - 1);
    localparam logic [14:0] STEP_LAST   = 15'(fault_sup_pkg::BLANK_STEP_CYC - 1);

    // registers
    logic [4:0]                 fault_source_mask_ff;
    logic [7:0]                 saturation_blank_interval_ff;
    logic [7:0]                 los_assert_level_ff;
    logic [7:0]                 los_deassert_level_ff;
    logic [7:0]                 bias_fault_set_ff;
    fault_sup_pkg::cfg_one_s    oem_config_one_ff;
    fault_sup_pkg::cfg_three_s  oem_config_three_ff;
    logic                       soft_tx_disable_ff;

    // fault state
    logic [4:0]                 raw_fault;
    logic [4:0]                 stable_ff;
    logic [19:0]                glitch_cnt_ff [fault_sup_pkg::NUM_SRC];
    logic [4:0]                 latched_ff;
    logic                       diode_fault_ff;
    logic                       conv_seen_ff;
    logic                       tx_disable_d_ff;
    logic                       clear_faults;
    logic                       ext_fault;
    logic                       any_fault;
    logic                       laser_off;
    logic                       laser_on_d_ff;
    logic [14:0]                step_cnt_ff;
    logic [7:0]                 blank_cnt_ff;
    logic                       blanking;
    logic                       los_state_ff;
    logic                       rx_los_pin;
    logic [7:0]                 rsel;

    function automatic logic [7:0] add_offset(input logic [7:0] base, input logic signed [7:0] ofs);
        logic signed [9:0] sum;
        sum = $signed({2'b00, base}) + 10'(ofs);
        if (sum < 0)
            add_offset = 8'h00;
        else if (sum > 10'sd255)
            add_offset = 8'hFF;
        else
            add_offset = sum[7:0];
    endfunction

    function automatic logic wr_hit(input logic [3:0] ofs);
        wr_hit = wr_in && (addr_in == ofs);
    endfunction

    // register writes; mask is assumed shadowed from nonvolatile store by software
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            fault_source_mask_ff         <= fault_sup_pkg::FAULT_MASK_RST;
            saturation_blank_interval_ff <= fault_sup_pkg::BLANK_RST;
            los_assert_level_ff          <= fault_sup_pkg::LOS_ASSERT_RST;
            los_deassert_level_ff        <= fault_sup_pkg::LOS_DEASSERT_RST;
            bias_fault_set_ff            <= fault_sup_pkg::BIAS_FLT_SET_RST;
            oem_config_one_ff            <= fault_sup_pkg::CFG_ONE_RST;
            oem_config_three_ff          <= fault_sup_pkg::CFG_THREE_RST;
            soft_tx_disable_ff           <= 1'b0;
        end
        else
        begin
            if (wr_hit(fault_sup_pkg::OFS_FAULT_MASK))
                fault_source_mask_ff <= wdata_in[4:0];
            if (wr_hit(fault_sup_pkg::OFS_BLANK))
                saturation_blank_interval_ff <= wdata_in;
            if (wr_hit(fault_sup_pkg::OFS_LOS_ASSERT))
                los_assert_level_ff <= wdata_in;
            if (wr_hit(fault_sup_pkg::OFS_LOS_DEASSERT))
                los_deassert_level_ff <= wdata_in;
            if (wr_hit(fault_sup_pkg::OFS_BIAS_FLT_SET))
                bias_fault_set_ff <= wdata_in;
            // flag bit is hardware owned, not writable
            if (wr_hit(fault_sup_pkg::OFS_CFG_ONE))
                oem_config_one_ff <= {wdata_in[7:3], diode_fault_ff, wdata_in[1:0]};
            else
                oem_config_one_ff.diode_fault_flag <= diode_fault_ff;
            if (wr_hit(fault_sup_pkg::OFS_CFG_THREE))
                oem_config_three_ff <= wdata_in;
            if (wr_hit(fault_sup_pkg::OFS_CONTROL))
                soft_tx_disable_ff <= wdata_in[0];
        end
    end

    // raw comparator levels and the external fault pin
    always_comb
    begin
        raw_fault                          = '0;
        raw_fault[fault_sup_pkg::SRC_SUPPLY] = sense_in.supply_low;
        raw_fault[fault_sup_pkg::SRC_DIODE]  = diode_fault_ff;
        raw_fault[fault_sup_pkg::SRC_BIAS]   = sense_in.bias_over;
        raw_fault[fault_sup_pkg::SRC_POWER]  = sense_in.power_over;
        raw_fault[fault_sup_pkg::SRC_SAT]    = sense_in.apc_saturated && !blanking;
    end

    assign ext_fault    = oem_config_three_ff.external_fault_mode &&
                          (safety_pin_in ^ ~oem_config_three_ff.ext_fault_input_polarity);
    assign clear_faults = tx_disable_in != tx_disable_d_ff;
    assign any_fault    = (|latched_ff) || ext_fault;
    assign laser_off    = tx_disable_in || soft_tx_disable_ff || any_fault;
    assign blanking     = blank_cnt_ff != 8'h00;

    // glitch filter: a level must hold a full window before it counts
    always_ff @(posedge clk_in)
    begin
        for (int i = 0; i < fault_sup_pkg::NUM_SRC; i++)
        begin
            if (!nrst_in || !raw_fault[i])
            begin
                glitch_cnt_ff[i] <= 20'h00000;
                stable_ff[i]     <= 1'b0;
            end
            else if (glitch_cnt_ff[i] == GLITCH_LAST)
                stable_ff[i] <= 1'b1;
            else
                glitch_cnt_ff[i] <= glitch_cnt_ff[i] + 20'h00001;
        end
    end

    // latch until tx disable toggles; a new fault wins over the clear
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            latched_ff <= 5'h00;
        else
            latched_ff <= (clear_faults ? 5'h00 : latched_ff) |
                          (stable_ff & ~fault_source_mask_ff);
    end

    // diode fault detection
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            diode_fault_ff  <= 1'b0;
            conv_seen_ff    <= 1'b0;
            tx_disable_d_ff <= 1'b1;
        end
        else
        begin
            tx_disable_d_ff <= tx_disable_in;
            if (sense_in.conv_done)
                conv_seen_ff <= 1'b1;
            if (conv_seen_ff && !tx_disable_in && sense_in.diode_open_short)
                diode_fault_ff <= 1'b1;
            else if (clear_faults)
                diode_fault_ff <= 1'b0;
        end
    end

    // blanking: restart on each laser turn-on, one step per half millisecond
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            laser_on_d_ff <= 1'b0;
            step_cnt_ff   <= 15'h0000;
            blank_cnt_ff  <= 8'h00;
        end
        else
        begin
            laser_on_d_ff <= !laser_off;
            if (!laser_off && !laser_on_d_ff)
            begin
                blank_cnt_ff <= saturation_blank_interval_ff;
                step_cnt_ff  <= 15'h0000;
            end
            else if (blanking)
            begin
                if (step_cnt_ff == STEP_LAST)
                begin
                    step_cnt_ff  <= 15'h0000;
                    blank_cnt_ff <= blank_cnt_ff - 8'h01;
                end
                else
                    step_cnt_ff <= step_cnt_ff + 15'h0001;
            end
        end
    end

    // loss-of-signal with hysteresis
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            los_state_ff <= 1'b1;
        else if (sense_in.rx_power_sense < los_assert_level_ff)
            los_state_ff <= 1'b1;
        else if (sense_in.rx_power_sense > los_deassert_level_ff)
            los_state_ff <= 1'b0;
    end

    // pin level seen when released, own drive otherwise
    assign rx_los_pin = oem_config_three_ff.los_comparator_disable ? rx_los_in : los_state_ff;

    // pin drivers
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            rx_los_out                 <= 1'b1;
            rx_los_oe_out              <= 1'b1;
            tx_fault_out               <= 1'b0;
            safety_switch_drive_out    <= 1'b0;
            safety_switch_drive_oe_out <= 1'b0;
            modulation_dac_out         <= '0;
            bias_dac_out               <= '0;
            laser_on_out               <= 1'b0;
        end
        else
        begin
            rx_los_out    <= los_state_ff;
            rx_los_oe_out <= !oem_config_three_ff.los_comparator_disable;
            tx_fault_out  <= any_fault;
            laser_on_out  <= !laser_off && oem_config_one_ff.output_enable;
            // shutdown levels: ground for 0, supply for 1; active is the complement
            safety_switch_drive_out <= laser_off ? oem_config_one_ff.safety_output_polarity
                                                 : !oem_config_one_ff.safety_output_polarity;
            safety_switch_drive_oe_out <= oem_config_one_ff.output_enable &&
                                          oem_config_three_ff.safety_enable &&
                                          !oem_config_three_ff.external_fault_mode;
            modulation_dac_out.drive  <= laser_off ? oem_config_one_ff.mod_ref_high
                                                   : !oem_config_one_ff.mod_ref_high;
            modulation_dac_out.enable <= oem_config_one_ff.output_enable;
            bias_dac_out.drive        <= laser_off ? oem_config_one_ff.bias_ref_high
                                                   : !oem_config_one_ff.bias_ref_high;
            bias_dac_out.enable       <= oem_config_one_ff.output_enable;
        end
    end

    // temperature path
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            temperature_out        <= 8'h00;
            temp_high_alarm_out    <= 1'b0;
            temp_high_warn_out     <= 1'b0;
            temp_zone_external_out <= 1'b0;
            bias_fault_ref_out     <= fault_sup_pkg::BIAS_FLT_SET_RST;
        end
        else
        begin
            temp_zone_external_out <= oem_config_one_ff.zone_external;
            if (diode_fault_ff)
                temperature_out <= fault_sup_pkg::TEMP_FULL_SCALE;
            else
                temperature_out <= oem_config_one_ff.zone_external ? sense_in.temp_external
                                                                   : sense_in.temp_internal;
            temp_high_alarm_out <= diode_fault_ff;
            temp_high_warn_out  <= diode_fault_ff;
            bias_fault_ref_out  <= add_offset(bias_fault_set_ff, bias_lut_offset_in);
        end
    end

    // read mux
    always_comb
    begin
        case (addr_in)
            fault_sup_pkg::OFS_FAULT_MASK:   rsel = {3'h0, fault_source_mask_ff};
            fault_sup_pkg::OFS_BLANK:        rsel = saturation_blank_interval_ff;
            fault_sup_pkg::OFS_LOS_ASSERT:   rsel = los_assert_level_ff;
            fault_sup_pkg::OFS_LOS_DEASSERT: rsel = los_deassert_level_ff;
            fault_sup_pkg::OFS_CFG_ONE:      rsel = oem_config_one_ff;
            fault_sup_pkg::OFS_CFG_THREE:    rsel = oem_config_three_ff;
            fault_sup_pkg::OFS_CONTROL:      rsel = {5'h00, rx_los_pin, any_fault, soft_tx_disable_ff};
            fault_sup_pkg::OFS_BIAS_FLT_SET: rsel = bias_fault_set_ff;
            fault_sup_pkg::OFS_TEMP:         rsel = temperature_out;
            fault_sup_pkg::OFS_FAULT_STAT:   rsel = {3'h0, latched_ff};
            default:                         rsel = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            rdata_out <= 8'h00;
        else if (rd_in)
            rdata_out <= rsel;
        else
            rdata_out <= 8'h00;
    end

endmodule // laser_fault_supervisor

// [tb/laser_fault_supervisor_checker.sv]
// Purpose: port assertions for the laser fault supervisor
// Assumes: one clock domain, sync active-low reset
// Notes:   the fault filter outlasts every run
`timescale 1ns/1ps
module laser_fault_supervisor_checker
(
    // clock and reset
    input wire logic                      clk_in,
    input wire logic                      nrst_in,
    // inputs watched
    input wire fault_sup_pkg::sense_s     sense_in,
    input wire logic                      tx_disable_in,
    // outputs watched
    input wire logic                      tx_fault_out,
    input wire fault_sup_pkg::pin_drive_s modulation_dac_out,
    input wire fault_sup_pkg::pin_drive_s bias_dac_out,
    input wire logic                      safety_switch_drive_oe_out,
    input wire logic                      laser_on_out,
    input wire logic [7:0]                temperature_out,
    input wire logic                      temp_high_alarm_out,
    input wire logic                      temp_high_warn_out
);
    logic [19:0] up_ff;
    logic        seen_ff;
    // saturating age counter
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            up_ff <= 20'h00000;
        else if (up_ff != 20'hFFFFF)
            up_ff <= up_ff + 20'h00001;
    end
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
            seen_ff <= 1'b0;
        else if (sense_in.conv_done)
            seen_ff <= 1'b1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_dis_held;
        tx_disable_in [*4];
    endsequence
    property p_float; !modulation_dac_out.enable |-> !safety_switch_drive_oe_out && !laser_on_out; endproperty
    property p_en_pair; modulation_dac_out.enable == bias_dac_out.enable; endproperty
    property p_fault_off; $rose(tx_fault_out) |-> ##[0:2] !laser_on_out; endproperty
    property p_dis_off; s_dis_held |-> !laser_on_out; endproperty
    property p_temp_fs; temp_high_alarm_out |-> temperature_out == fault_sup_pkg::TEMP_FULL_SCALE; endproperty
    property p_warn; temp_high_alarm_out == temp_high_warn_out; endproperty
    property p_early; !seen_ff |-> !temp_high_alarm_out; endproperty
    property p_dis_diode; s_dis_held |-> !$rose(temp_high_alarm_out); endproperty
    property p_glitch; (up_ff < fault_sup_pkg::GLITCH_CYC) && safety_switch_drive_oe_out
        |-> !tx_fault_out; endproperty
    a_float: assert property (p_float) else $error("outputs driven while disabled");
    a_en_pair: assert property (p_en_pair) else $error("dac enables differ");
    a_fault_off: assert property (p_fault_off) else $error("laser on after fault");
    a_dis_off: assert property (p_dis_off) else $error("laser on while disabled");
    a_temp_fs: assert property (p_temp_fs) else $error("temperature not full scale");
    a_warn: assert property (p_warn) else $error("alarm and warning differ");
    a_early: assert property (p_early) else $error("diode fault before conversion");
    a_dis_diode: assert property (p_dis_diode) else $error("diode fault while disabled");
    a_glitch: assert property (p_glitch) else $error("fault faster than filter");
endmodule // laser_fault_supervisor_checker

bind laser_fault_supervisor laser_fault_supervisor_checker u_chk
(
    .clk_in, .nrst_in, .sense_in, .tx_disable_in, .tx_fault_out, .modulation_dac_out, .bias_dac_out,
    .safety_switch_drive_oe_out, .laser_on_out, .temperature_out, .temp_high_alarm_out, .temp_high_warn_out
);

// [tb/fault_sup_far_side.sv]
// Purpose: host and driver side of the shared pins
// Assumes: rx los line pulled up, safety line pulled down
// Notes:   an undriven line never keeps the design's last value
`timescale 1ns/1ps
module fault_sup_far_side
(
    // design pin drives
    input  wire logic rx_los_out,
    input  wire logic rx_los_oe_out,
    input  wire logic safety_switch_drive_out,
    input  wire logic safety_switch_drive_oe_out,
    // far side drivers
    input  wire logic host_los_en_in,
    input  wire logic host_los_in,
    // resolved pin levels
    output logic      rx_los_pin_out,
    output logic      safety_pin_out
);
    // host may only drive once the comparator has let go
    assign rx_los_pin_out = rx_los_oe_out ? rx_los_out : (host_los_en_in ? host_los_in : 1'b1);
    assign safety_pin_out = safety_switch_drive_oe_out ? safety_switch_drive_out : 1'b0;
endmodule // fault_sup_far_side

// [tb/laser_fault_supervisor_tb.sv]
// Purpose: register and pin level tests of the fault supervisor
// Assumes: fixed 500000-cycle filter, so only rejection is exercised
// Notes:   registered outputs are sampled a few cycles after their cause
`timescale 1ns/1ps
module laser_fault_supervisor_tb;
    logic                      clk_in, nrst_in, wr_in, rd_in, tx_disable_in, pol, host_los_en, host_los;
    logic [3:0]                addr_in;
    logic [7:0]                wdata_in, rdata_out, bias_fault_ref_out, temperature_out, d;
    logic signed [7:0]         bias_lut_offset_in;
    fault_sup_pkg::sense_s     sense_in;
    fault_sup_pkg::pin_drive_s modulation_dac_out, bias_dac_out;
    logic                      rx_los_in, rx_los_out, rx_los_oe_out, safety_pin_in;
    logic                      safety_switch_drive_out, safety_switch_drive_oe_out, laser_on_out, tx_fault_out;
    logic                      temp_zone_external_out, temp_high_alarm_out, temp_high_warn_out;
    int                        fails, compares;
    logic [7:0] rv [16] = '{1:8'h01, 2:8'h20, 3:8'h30, 6:8'h04, 7:8'hC0, default:8'h00};
    logic [7:0] pw [5] = '{8'h10, 8'h28, 8'h40, 8'h28, 8'h10};
    logic [4:0] los_exp = 5'b10011;
    logic [7:0] bs [4] = '{8'hC0, 8'hC0, 8'hC0, 8'h10};
    logic [7:0] bo [4] = '{8'h00, 8'h50, 8'hF0, 8'hE0};
    logic [7:0] be [4] = '{8'hC0, 8'hFF, 8'hB0, 8'h00};
    laser_fault_supervisor u_dut (.*);
    fault_sup_far_side u_far (.rx_los_out, .rx_los_oe_out, .safety_switch_drive_out, .safety_switch_drive_oe_out,
        .host_los_en_in(host_los_en), .host_los_in(host_los), .rx_los_pin_out(rx_los_in), .safety_pin_out(safety_pin_in));
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= v;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk8(name, exp, rdata_out);
    endtask
    task automatic summarize();
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk_in);
        fails++;
        summarize();
    end
    initial
    begin
        {nrst_in, wr_in, rd_in, host_los_en, host_los} = 5'h00;
        {addr_in, wdata_in, bias_lut_offset_in} = 20'h00000;
        tx_disable_in = 1'b1;
        sense_in = '0;
        sense_in.rx_power_sense = 8'h10;
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'b1;
        for (int i = 0; i < 16; i++) rd_chk(i[3:0], rv[i], "reset value");
        reg_wr(fault_sup_pkg::OFS_FAULT_MASK, 8'h1F);
        rd_chk(fault_sup_pkg::OFS_FAULT_MASK, 8'h1F, "mask");
        reg_wr(4'hC, 8'hAA);
        rd_chk(4'hC, 8'h00, "unmapped");
        reg_wr(fault_sup_pkg::OFS_FAULT_MASK, 8'h00);
        reg_wr(fault_sup_pkg::OFS_CFG_ONE, 8'h24);
        rd_chk(fault_sup_pkg::OFS_CFG_ONE, 8'h20, "cfg one");
        chk8("zone", 8'h01, {7'h00, temp_zone_external_out});
        reg_wr(fault_sup_pkg::OFS_CFG_THREE, 8'h80);
        settle(3);
        chk8("float", 8'h00, {6'h00, bias_dac_out.enable, safety_switch_drive_oe_out});
        for (int p = 0; p < 2; p++)
        begin
            pol = p[0];
            reg_wr(fault_sup_pkg::OFS_CFG_ONE, {1'b1, pol, 1'b0, pol, ~pol, 3'b000});
            tx_disable_in <= 1'b1;
            settle(4);
            chk8("off levels", {4'h1, pol, pol, ~pol, 1'b1}, {3'h0, safety_switch_drive_oe_out,
                safety_switch_drive_out, bias_dac_out.drive, modulation_dac_out.drive, bias_dac_out.enable});
            tx_disable_in <= 1'b0;
            reg_wr(fault_sup_pkg::OFS_CONTROL, 8'h01);
            settle(4);
            chk8("soft off", {7'h00, pol}, {7'h00, safety_switch_drive_out});
            reg_wr(fault_sup_pkg::OFS_CONTROL, 8'h00);
            settle(4);
            chk8("running", {7'h00, ~pol}, {7'h00, safety_switch_drive_out});
        end
        for (int i = 0; i < 5; i++)
        begin
            sense_in.rx_power_sense <= pw[i];
            settle(4);
            chk8("rx los", {7'h00, los_exp[i]}, {7'h00, rx_los_out});
            rd_chk(fault_sup_pkg::OFS_CONTROL, {5'h00, los_exp[i], 2'b00}, "los status");
        end
        reg_wr(fault_sup_pkg::OFS_CFG_THREE, 8'h90);
        settle(2);
        chk8("los release", 8'h00, {7'h00, rx_los_oe_out});
        host_los_en <= 1'b1;
        rd_chk(fault_sup_pkg::OFS_CONTROL, 8'h00, "host los low");
        host_los <= 1'b1;
        rd_chk(fault_sup_pkg::OFS_CONTROL, 8'h04, "host los high");
        reg_wr(fault_sup_pkg::OFS_CFG_THREE, 8'hD0);
        rd_chk(fault_sup_pkg::OFS_CONTROL, 8'h06, "ext fault");
        chk8("tx fault", 8'h01, {7'h00, tx_fault_out});
        reg_wr(fault_sup_pkg::OFS_CFG_THREE, 8'h90);
        for (int i = 0; i < 4; i++)
        begin
            reg_wr(fault_sup_pkg::OFS_BIAS_FLT_SET, bs[i]);
            bias_lut_offset_in <= bo[i];
            settle(4);
            chk8("bias ref", be[i], bias_fault_ref_out);
        end
        // every source at once, but shorter than the filter window
        sense_in.conv_done <= 1'b1;
        {sense_in.supply_low, sense_in.bias_over, sense_in.power_over} <= 3'b111;
        {sense_in.apc_saturated, sense_in.diode_open_short} <= 2'b11;
        settle(1);
        sense_in.conv_done <= 1'b0;
        settle(2000);
        chk8("glitch", 8'h00, {7'h00, tx_fault_out});
        chk8("diode temp", 8'h7F, temperature_out);
        sense_in <= '0;
        rd_chk(fault_sup_pkg::OFS_FAULT_STAT, 8'h00, "latched faults");
        summarize();
    end
endmodule // laser_fault_supervisor_tb
